/* File: src/mdfr_pkg.sv */
package mdfr_pkg;

	// Register byte addresses
	localparam logic [7:0] MDFR_CTRL_ADDR = 8'h00;
	localparam logic [7:0] MDFR_CFG_ADDR  = 8'h04;
	localparam logic [7:0] MDFR_STAT_ADDR = 8'h08;
	localparam logic [7:0] MDFR_MASK_ADDR = 8'h0C;
	localparam logic [7:0] MDFR_BRG_ADDR  = 8'h10;

	// Control register fields (write only pulses)
	localparam int MDFR_CTRL_CLR_BIT = 0;

	// Configuration register fields
	localparam int MDFR_CFG_MODE_LSB = 0;
	localparam int MDFR_CFG_TOEN_BIT = 4;
	localparam int MDFR_CFG_ALDS_BIT = 5;
	localparam logic [31:0] MDFR_CFG_RESET = 32'h0000_0010;

	// Status and mask bit positions
	localparam int MDFR_ST_CTRL_FLT = 0;
	localparam int MDFR_ST_DRV_FLT  = 1;
	localparam int MDFR_ST_SWLIM    = 2;
	localparam int MDFR_ST_RAMPUP   = 3;
	localparam int MDFR_ST_RAMPDN   = 4;
	localparam int MDFR_ST_RATE     = 5;
	localparam int MDFR_ST_MPOS     = 6;
	localparam int MDFR_ST_MEMF     = 7;
	localparam int MDFR_ST_CHARGE_PUMP_UNDERVOLTAGE     = 8;
	localparam int MDFR_ST_W        = 9;
	localparam logic [8:0] MDFR_MASK_RESET = 9'h1_FF;

	// Timing figures
	localparam int MDFR_CLK_HZ        = 25_000_000;
	localparam int MDFR_POS_TMO_MS    = 500;
	localparam int MDFR_POS_TMO_CYC   = MDFR_CLK_HZ / 1000 * MDFR_POS_TMO_MS;
	localparam int MDFR_RETRY_MS      = 500;
	localparam int MDFR_RETRY_CYC     = MDFR_CLK_HZ / 1000 * MDFR_RETRY_MS;

	// Bridge state encoding
	typedef enum logic [2:0] {
		MDFR_BR_ACTIVE = 3'b000,
		MDFR_BR_HIZ    = 3'b001,
		MDFR_BR_RECIRC = 3'b010,
		MDFR_BR_HSBRK  = 3'b011,
		MDFR_BR_LSBRK  = 3'b100
	} mdfr_bridge_type;

	// Software current limit supervisor states
	typedef enum logic [1:0] {
		MDFR_LIM_IDLE  = 2'b00,
		MDFR_LIM_LATCH = 2'b01,
		MDFR_LIM_RETRY = 2'b10,
		MDFR_LIM_RPT   = 2'b11
	} mdfr_lim_type;

endpackage

/* File: src/mdfr_top.sv */
`timescale 1ns/1ps
module mdfr_top
	import mdfr_pkg::*;
#(
	parameter int POS_TMO_CYC = MDFR_POS_TMO_CYC,
	parameter int RETRY_CYC   = MDFR_RETRY_CYC
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// AXI4-Lite slave
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// Analog comparator and controller inputs
	input  wire logic        MAIN_SUPPLY_UV,
	input  wire logic        ANALOG_REGULATOR_UV,
	input  wire logic        BUCK_UNDERVOLTAGE,
	input  wire logic        CHARGE_PUMP_UNDERVOLTAGE,
	input  wire logic        SW_CURRENT_LIMIT_FAULT,
	input  wire logic        POS_RAMP_UP,
	input  wire logic        POS_RAMP_DOWN,
	input  wire logic        POS_PULSE_START,
	input  wire logic        POS_CURRENT_DECAYED,
	input  wire logic        PARAM_MEASURE_CMD,
	input  wire logic        PARAM_MEASURE_RESISTANCE,
	input  wire logic        PARAM_MEASURE_INDUCTANCE,
	input  wire logic        PARAM_MEASURE_EMF_LOW,
	// Outputs
	output logic [2:0]       BRIDGE_STATE,
	output logic             CHARGE_PUMP_EN,
	output logic             BUCK_HS_EN,
	output logic             BUCK_LS_EN,
	output logic             LOGIC_RST,
	output logic             FAULT_OUT_N,
	output logic             IRQ
);

	// Internal reset: pin reset or main, regulator or buck undervoltage (not pump loss)
	// A brown-out resets every register, so no fault state outlives it
	logic rst_all;
	assign rst_all = RST | MAIN_SUPPLY_UV | ANALOG_REGULATOR_UV
		| BUCK_UNDERVOLTAGE;

	// Buck switches off while feedback is low
	assign BUCK_HS_EN = ~BUCK_UNDERVOLTAGE;
	assign BUCK_LS_EN = ~BUCK_UNDERVOLTAGE;
	// Pump and logic held down on main or regulator loss
	assign CHARGE_PUMP_EN = ~(MAIN_SUPPLY_UV | ANALOG_REGULATOR_UV);
	assign LOGIC_RST      = rst_all;

	// Software-visible registers
	logic [31:0]         cfg_r;       // Action code, enables
	logic [MDFR_ST_W-1:0] stat_r;     // Sticky status
	logic [MDFR_ST_W-1:0] mask_r;     // Interrupt enables
	logic                clr_pulse;   // Clear-fault command pulse

	logic [3:0] sw_current_limit_action_sel;
	logic       pos_detect_timeout_en;
	logic       alarm_pin_disable;
	assign sw_current_limit_action_sel = cfg_r[MDFR_CFG_MODE_LSB +: 4];
	assign pos_detect_timeout_en       = cfg_r[MDFR_CFG_TOEN_BIT];
	assign alarm_pin_disable           = cfg_r[MDFR_CFG_ALDS_BIT];

	// AXI write channel capture; address and data taken in either order
	logic       aw_got_r, w_got_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic       wr_fire;
	// Readies drop while a response waits: one write at a time
	assign S_AXI_AWREADY = ~aw_got_r & ~S_AXI_BVALID;
	assign S_AXI_WREADY  = ~w_got_r & ~S_AXI_BVALID;
	assign wr_fire       = aw_got_r & w_got_r;

	// Hold address and data until both present
	// Each channel is taken on its own edge; the write fires once both are held
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else if (wr_fire) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_r  <= 1'b1;
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	// The response code stays with BVALID until the master takes it
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= 2'b00;
		end else if (wr_fire) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= (aw_addr_r == MDFR_CTRL_ADDR || aw_addr_r == MDFR_CFG_ADDR
				|| aw_addr_r == MDFR_STAT_ADDR || aw_addr_r == MDFR_MASK_ADDR)
				? 2'b00 : 2'b10;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Clear command is a one-cycle pulse from a control write
	// Only byte lane 0 carries the clear bit
	assign clr_pulse = wr_fire && aw_addr_r == MDFR_CTRL_ADDR && w_strb_r[0]
		&& w_data_r[MDFR_CTRL_CLR_BIT];

	// Configuration and mask registers, byte-lane writes
	// Only the low byte of the configuration is built; other lanes are ignored
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all) begin
			cfg_r  <= MDFR_CFG_RESET;
			mask_r <= MDFR_MASK_RESET;
		end else if (wr_fire) begin
			if (aw_addr_r == MDFR_CFG_ADDR && w_strb_r[0])
				cfg_r[7:0] <= w_data_r[7:0];
			if (aw_addr_r == MDFR_MASK_ADDR) begin
				if (w_strb_r[0])
					mask_r[7:0] <= w_data_r[7:0];
				if (w_strb_r[1])
					mask_r[8] <= w_data_r[8];
			end
		end
	end

	// Position-detect ramp timer; ramp signals are levels
	// The count stops at the limit, so the cause stays present while the ramp lasts
	logic [31:0] ramp_cnt_r;
	logic        ramp_active;
	logic        ramp_tmo;
	assign ramp_active = POS_RAMP_UP | POS_RAMP_DOWN;
	assign ramp_tmo    = ramp_active && ramp_cnt_r >= 32'(POS_TMO_CYC - 1);
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all)
			ramp_cnt_r <= 32'h0000_0000;
		else if (!ramp_active)
			ramp_cnt_r <= 32'h0000_0000;
		else if (!ramp_tmo)
			ramp_cnt_r <= ramp_cnt_r + 32'h0000_0001;
	end

	// Measurement in progress redirects timeouts to its own flag
	logic measuring;
	assign measuring = PARAM_MEASURE_CMD | PARAM_MEASURE_RESISTANCE
		| PARAM_MEASURE_INDUCTANCE;

	// Fault events
	// A measurement takes the timeout over, so one timeout gives one flag
	// The rate fault shares the timeout enable
	logic ev_up, ev_dn, ev_rate, ev_mpos, ev_memf;
	assign ev_up   = pos_detect_timeout_en & ramp_tmo & POS_RAMP_UP & ~measuring;
	assign ev_dn   = pos_detect_timeout_en & ramp_tmo & POS_RAMP_DOWN & ~measuring;
	assign ev_rate = pos_detect_timeout_en & POS_PULSE_START & ~POS_CURRENT_DECAYED;
	assign ev_mpos = measuring & ramp_tmo;
	assign ev_memf = PARAM_MEASURE_CMD & PARAM_MEASURE_EMF_LOW;

	// Latched Hi-Z shutdown from detect and measurement faults
	// An event in the clear cycle wins, so a live fault is never dropped
	logic hiz_latch_r;
	logic hiz_cause;
	assign hiz_cause = ramp_tmo | ~POS_CURRENT_DECAYED | PARAM_MEASURE_EMF_LOW;
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all)
			hiz_latch_r <= 1'b0;
		else if (ev_up | ev_dn | ev_rate | ev_mpos | ev_memf)
			hiz_latch_r <= 1'b1;
		else if (clr_pulse && !hiz_cause)
			hiz_latch_r <= 1'b0;
	end

	// Codes 1xx1 disable the limit; every other code acts on it
	logic lim_act;
	assign lim_act = SW_CURRENT_LIMIT_FAULT
		&& !(sw_current_limit_action_sel[3] && sw_current_limit_action_sel[0]);

	// Software current limit supervisor
	// The bridge state is chosen once, at the event, and held meanwhile
	mdfr_lim_type    lim_st_r;
	mdfr_bridge_type lim_br_r;
	logic [31:0]     retry_cnt_r;
	logic            lim_pin;
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all) begin
			lim_st_r    <= MDFR_LIM_IDLE;
			lim_br_r    <= MDFR_BR_ACTIVE;
			retry_cnt_r <= 32'h0000_0000;
		end else begin
			unique case (lim_st_r)
				MDFR_LIM_IDLE: begin
					if (lim_act) begin
						retry_cnt_r <= 32'h0000_0000;
						// Low two bits pick the bridge state
						unique case (sw_current_limit_action_sel[1:0])
							2'b00: lim_br_r <= MDFR_BR_HIZ;
							2'b01: lim_br_r <= MDFR_BR_RECIRC;
							2'b10: lim_br_r <= MDFR_BR_HSBRK;
							2'b11: lim_br_r <= MDFR_BR_LSBRK;
						endcase
						if (sw_current_limit_action_sel[3]) begin
							lim_st_r <= MDFR_LIM_RPT;
							lim_br_r <= MDFR_BR_ACTIVE;
						end else if (sw_current_limit_action_sel[2])
							lim_st_r <= MDFR_LIM_RETRY;
						else
							lim_st_r <= MDFR_LIM_LATCH;
					end
				end
				MDFR_LIM_LATCH, MDFR_LIM_RPT: begin
					// Released only once the limit has gone away
					if (clr_pulse && !SW_CURRENT_LIMIT_FAULT) begin
						lim_st_r <= MDFR_LIM_IDLE;
						lim_br_r <= MDFR_BR_ACTIVE;
					end
				end
				MDFR_LIM_RETRY: begin
					// A limit still present when the time is up re-arms at once
					if (retry_cnt_r >= 32'(RETRY_CYC - 1)) begin
						lim_st_r <= MDFR_LIM_IDLE;
						lim_br_r <= MDFR_BR_ACTIVE;
					end else
						retry_cnt_r <= retry_cnt_r + 32'h0000_0001;
				end
			endcase
		end
	end
	// Report-only pin obeys alarm disable
	assign lim_pin = (lim_st_r == MDFR_LIM_LATCH) || (lim_st_r == MDFR_LIM_RETRY)
		|| (lim_st_r == MDFR_LIM_RPT && !alarm_pin_disable);

	// Sticky status: set wins over write-one-to-clear
	// A clear command keeps only the events of its own cycle
	logic [MDFR_ST_W-1:0] ev_vec;
	logic [MDFR_ST_W-1:0] w1c;
	logic                 lim_ev;
	assign lim_ev = (lim_st_r == MDFR_LIM_IDLE) && lim_act;
	always_comb begin
		ev_vec = '0;
		ev_vec[MDFR_ST_SWLIM]    = lim_ev;
		ev_vec[MDFR_ST_RAMPUP]   = ev_up;
		ev_vec[MDFR_ST_RAMPDN]   = ev_dn;
		ev_vec[MDFR_ST_RATE]     = ev_rate;
		ev_vec[MDFR_ST_MPOS]     = ev_mpos;
		ev_vec[MDFR_ST_MEMF]     = ev_memf;
		ev_vec[MDFR_ST_CHARGE_PUMP_UNDERVOLTAGE]     = CHARGE_PUMP_UNDERVOLTAGE;
		ev_vec[MDFR_ST_DRV_FLT]  = CHARGE_PUMP_UNDERVOLTAGE;
		ev_vec[MDFR_ST_CTRL_FLT] = lim_ev | ev_up | ev_dn | ev_rate | ev_mpos | ev_memf;
	end
	assign w1c = (wr_fire && aw_addr_r == MDFR_STAT_ADDR)
		? (w_data_r[MDFR_ST_W-1:0] & {w_strb_r[1], {8{w_strb_r[0]}}}) : '0;
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all)
			stat_r <= '0;
		else if (clr_pulse)
			stat_r <= ev_vec;
		else
			stat_r <= (stat_r & ~w1c) | ev_vec;
	end
	// Level interrupt, high while any enabled flag is set
	assign IRQ = |(stat_r & mask_r);

	// Read channel
	// Data is answered one cycle after the address is taken
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= 2'b00;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP  <= 2'b00;
			unique case (S_AXI_ARADDR)
				MDFR_CTRL_ADDR: S_AXI_RDATA <= 32'h0000_0000;
				MDFR_CFG_ADDR:  S_AXI_RDATA <= {24'h00_0000, cfg_r[7:0]};
				MDFR_STAT_ADDR: S_AXI_RDATA <= {23'h00_0000, stat_r};
				MDFR_MASK_ADDR: S_AXI_RDATA <= {23'h00_0000, mask_r};
				MDFR_BRG_ADDR:  S_AXI_RDATA <= {29'h0000_0000, BRIDGE_STATE};
				default: begin
					S_AXI_RDATA <= 32'h0000_0000;
					S_AXI_RRESP <= 2'b10;
				end
			endcase
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
	assign S_AXI_ARREADY = ~S_AXI_RVALID;

	// Bridge and fault pin; pump loss overrides and recovers by itself
	// Registered so the bridge and the pin never show decode glitches
	// Pump loss needs no clear: the override drops with the condition
	always_ff @(posedge SYS_CLK or posedge rst_all) begin
		if (rst_all) begin
			BRIDGE_STATE <= MDFR_BR_HIZ;
			FAULT_OUT_N  <= 1'b1;
		end else begin
			if (CHARGE_PUMP_UNDERVOLTAGE || hiz_latch_r)
				BRIDGE_STATE <= MDFR_BR_HIZ;
			else
				BRIDGE_STATE <= lim_br_r;
			FAULT_OUT_N <= ~(CHARGE_PUMP_UNDERVOLTAGE | hiz_latch_r | lim_pin);
		end
	end

endmodule // mdfr_top

/* File: dv/mdfr_top_sva.sv */
`timescale 1ns/1ps
// Port checks of supply, fault pin and bus answers
module mdfr_top_sva
	import mdfr_pkg::*;
#(
	parameter int POS_TMO_CYC = MDFR_POS_TMO_CYC
) (
	input wire logic       SYS_CLK,
	input wire logic       RST,
	input wire logic       MAIN_SUPPLY_UV,
	input wire logic       ANALOG_REGULATOR_UV,
	input wire logic       BUCK_UNDERVOLTAGE,
	input wire logic       CHARGE_PUMP_UNDERVOLTAGE,
	input wire logic       POS_RAMP_UP,
	input wire logic       S_AXI_ARVALID,
	input wire logic       S_AXI_ARREADY,
	input wire logic       S_AXI_RVALID,
	input wire logic       S_AXI_RREADY,
	input wire logic       S_AXI_BVALID,
	input wire logic       S_AXI_BREADY,
	input wire logic [2:0] BRIDGE_STATE,
	input wire logic       CHARGE_PUMP_EN,
	input wire logic       BUCK_HS_EN,
	input wire logic       BUCK_LS_EN,
	input wire logic       LOGIC_RST,
	input wire logic       FAULT_OUT_N
);
	// Supply undervoltage resets the logic just as RST does
	wire any_rst = RST | MAIN_SUPPLY_UV | ANALOG_REGULATOR_UV | BUCK_UNDERVOLTAGE;
	int  ramp_r; // Cycles of unbroken ramp-up, saturating
	// Counter instead of a long repetition keeps the tools fast
	always_ff @(posedge SYS_CLK or posedge any_rst) begin
		if (any_rst)
			ramp_r <= 0;
		else
			ramp_r <= POS_RAMP_UP ? ramp_r + (ramp_r < POS_TMO_CYC + 8) : 0;
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (any_rst);
	// Supply checks must stay live while the supply itself resets the logic
	property p_main; disable iff (RST)
		MAIN_SUPPLY_UV |-> !CHARGE_PUMP_EN && LOGIC_RST && BRIDGE_STATE == MDFR_BR_HIZ; endproperty
	a_main: assert property (p_main) else $error("main uv");
	property p_areg; disable iff (RST)
		ANALOG_REGULATOR_UV |-> !CHARGE_PUMP_EN && LOGIC_RST; endproperty
	a_areg: assert property (p_areg) else $error("regulator uv");
	property p_buck; disable iff (RST)
		BUCK_UNDERVOLTAGE |-> !BUCK_HS_EN && !BUCK_LS_EN && LOGIC_RST; endproperty
	a_buck: assert property (p_buck) else $error("buck_undervoltage");
	property p_pump;
		CHARGE_PUMP_UNDERVOLTAGE |=> BRIDGE_STATE == MDFR_BR_HIZ && !FAULT_OUT_N; endproperty
	a_pump: assert property (p_pump) else $error("pump uv");
	property p_ramp;
		ramp_r == POS_TMO_CYC + 4 |-> BRIDGE_STATE == MDFR_BR_HIZ && !FAULT_OUT_N; endproperty
	a_ramp: assert property (p_ramp) else $error("ramp timeout");
	property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
	a_rlat: assert property (p_rlat) else $error("read latency");
	property p_rend; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
	a_rend: assert property (p_rend) else $error("read repeat");
	property p_bend; S_AXI_BVALID && S_AXI_BREADY |=> $fell(S_AXI_BVALID); endproperty
	a_bend: assert property (p_bend) else $error("write repeat");
endmodule // mdfr_top_sva
bind mdfr_top mdfr_top_sva #(.POS_TMO_CYC(POS_TMO_CYC)) u_sva (.*);

/* File: dv/mdfr_fault_mon.sv */
`timescale 1ns/1ps
// System controller side: remembers any alarm on the fault pin
module mdfr_fault_mon (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic fault_out_n,
	output logic      fault_seen
);
	// Sticky so short alarms between bench checks are not lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fault_seen <= 1'b0;
		else if (!fault_out_n)
			fault_seen <= 1'b1;
	end
endmodule // mdfr_fault_mon

/* File: dv/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the fault response block
module testbench;
	import mdfr_pkg::*;
	localparam int TMO = 20; // Short timeout keeps the run brief
	localparam int RTY = 10; // Short retry time
	logic SYS_CLK = '0, RST = '1;
	logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rd;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
	logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
	logic MAIN_SUPPLY_UV = '0, ANALOG_REGULATOR_UV = '0, BUCK_UNDERVOLTAGE = '0;
	logic CHARGE_PUMP_UNDERVOLTAGE = '0, SW_CURRENT_LIMIT_FAULT = '0, POS_RAMP_UP = '0;
	logic POS_RAMP_DOWN = '0, POS_PULSE_START = '0, POS_CURRENT_DECAYED = '1;
	logic PARAM_MEASURE_CMD = '0, PARAM_MEASURE_RESISTANCE = '0;
	logic PARAM_MEASURE_INDUCTANCE = '0, PARAM_MEASURE_EMF_LOW = '0;
	logic [2:0] BRIDGE_STATE;
	logic CHARGE_PUMP_EN, BUCK_HS_EN, BUCK_LS_EN, LOGIC_RST, FAULT_OUT_N, IRQ, seen;
	int fails = 0, tests_run = 0;
	mdfr_bridge_type tab [4] = '{MDFR_BR_HIZ, MDFR_BR_RECIRC, MDFR_BR_HSBRK, MDFR_BR_LSBRK};
	mdfr_top #(.POS_TMO_CYC(TMO), .RETRY_CYC(RTY)) DUT (.*);
	mdfr_fault_mon MON (.clk(SYS_CLK), .rst(RST), .fault_out_n(FAULT_OUT_N), .fault_seen(seen));
	always #20 SYS_CLK = ~SYS_CLK;
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	// Settle point: outputs are read at the falling edge
	task automatic wt(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask
	// One bus write (w=1) or read; readies sampled at the negedge before the taking edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic aw, wd, ar, b;
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_ARADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= w;
		S_AXI_WVALID <= w;
		S_AXI_BREADY <= w;
		S_AXI_ARVALID <= !w;
		S_AXI_RREADY <= !w;
		b = 1'b0;
		// No cycle count is assumed; the watchdog ends a hung wait
		while (!b) begin
			@(negedge SYS_CLK);
			aw = S_AXI_AWREADY;
			wd = S_AXI_WREADY;
			ar = S_AXI_ARREADY;
			b = w ? S_AXI_BVALID : S_AXI_RVALID;
			rs = w ? S_AXI_BRESP : S_AXI_RRESP;
			rd = S_AXI_RDATA;
			@(posedge SYS_CLK);
			if (aw) S_AXI_AWVALID <= 1'b0;
			if (wd) S_AXI_WVALID <= 1'b0;
			if (ar) S_AXI_ARVALID <= 1'b0;
		end
		S_AXI_BREADY <= 1'b0;
		S_AXI_RREADY <= 1'b0;
		chk("bus taken", 3'h0, {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID});
	endtask
	task automatic clr;
		bus(1, MDFR_CTRL_ADDR, 32'h0000_0001);
	endtask
	task automatic t_reset;
		bus(0, MDFR_CFG_ADDR, '0);
		chk("cfg reset", MDFR_CFG_RESET, rd);
		bus(0, MDFR_MASK_ADDR, '0);
		chk("mask reset", MDFR_MASK_RESET, rd);
		bus(0, 8'h20, '0);
		chk("unmapped", 2'h2, rs);
		bus(1, MDFR_BRG_ADDR, '0);
		chk("ro write", 2'h2, rs);
		wt(1);
		chk("bridge", MDFR_BR_ACTIVE, BRIDGE_STATE);
		$display("t_reset done");
	endtask
	// Latched codes hold past the retry time; retry codes come back alone
	task automatic t_limit;
		for (int m = 0; m < 8; m++) begin
			bus(1, MDFR_CFG_ADDR, 32'h0000_0010 | m);
			SW_CURRENT_LIMIT_FAULT <= 1'b1;
			wt(3);
			chk("lim bridge", tab[m % 4], BRIDGE_STATE);
			chk("lim pin", 0, FAULT_OUT_N);
			@(posedge SYS_CLK);
			SW_CURRENT_LIMIT_FAULT <= 1'b0;
			wt(RTY + 4);
			chk("lim hold", m < 4 ? tab[m % 4] : MDFR_BR_ACTIVE, BRIDGE_STATE);
			chk("lim hold pin", m < 4 ? 0 : 1, FAULT_OUT_N);
			clr;
			wt(2);
			chk("lim clear", MDFR_BR_ACTIVE, BRIDGE_STATE);
		end
		$display("t_limit done");
	endtask
	// Report-only with pin on, pin off, then the disabled code
	task automatic t_report;
		logic [7:0] rc [3] = '{8'h18, 8'h38, 8'h19};
		for (int k = 0; k < 3; k++) begin
			bus(1, MDFR_CFG_ADDR, rc[k]);
			SW_CURRENT_LIMIT_FAULT <= 1'b1;
			wt(3);
			chk("rep bridge", MDFR_BR_ACTIVE, BRIDGE_STATE);
			chk("rep pin", k != 0, FAULT_OUT_N);
			@(posedge SYS_CLK);
			SW_CURRENT_LIMIT_FAULT <= 1'b0;
			bus(0, MDFR_STAT_ADDR, '0);
			chk("rep flag", k < 2, rd[MDFR_ST_SWLIM]);
			clr;
			wt(2);
			chk("rep release", 1, FAULT_OUT_N);
		end
		$display("t_report done");
	endtask
	// Ramp-up, ramp-down, ramps during three measurement kinds, then a weak emf
	task automatic t_ramp;
		int bt [6] = '{MDFR_ST_RAMPUP, MDFR_ST_RAMPDN, MDFR_ST_MPOS, MDFR_ST_MPOS,
			MDFR_ST_MPOS, MDFR_ST_MEMF};
		for (int k = 0; k < 6; k++) begin
			@(posedge SYS_CLK);
			POS_RAMP_UP <= (k != 1 && k != 5);
			POS_RAMP_DOWN <= (k == 1);
			PARAM_MEASURE_CMD <= (k == 2 || k == 5);
			PARAM_MEASURE_RESISTANCE <= (k == 3);
			PARAM_MEASURE_INDUCTANCE <= (k == 4);
			PARAM_MEASURE_EMF_LOW <= (k == 5);
			wt(TMO + 4);
			chk("ramp bridge", MDFR_BR_HIZ, BRIDGE_STATE);
			chk("ramp pin", 0, FAULT_OUT_N);
			bus(0, MDFR_STAT_ADDR, '0);
			chk("ramp flag", 1, rd[bt[k]]);
			clr;
			wt(2);
			chk("ramp held", MDFR_BR_HIZ, BRIDGE_STATE);
			@(posedge SYS_CLK);
			{POS_RAMP_UP, POS_RAMP_DOWN, PARAM_MEASURE_CMD, PARAM_MEASURE_RESISTANCE,
				PARAM_MEASURE_INDUCTANCE, PARAM_MEASURE_EMF_LOW} <= '0;
			clr;
			wt(2);
			chk("ramp clear", MDFR_BR_ACTIVE, BRIDGE_STATE);
		end
		$display("t_ramp done");
	endtask
	task automatic t_rate;
		@(posedge SYS_CLK);
		POS_CURRENT_DECAYED <= 1'b0;
		POS_PULSE_START <= 1'b1;
		@(posedge SYS_CLK);
		POS_PULSE_START <= 1'b0;
		wt(2);
		chk("rate bridge", MDFR_BR_HIZ, BRIDGE_STATE);
		chk("rate pin", 0, FAULT_OUT_N);
		bus(0, MDFR_STAT_ADDR, '0);
		chk("rate flag", 1, rd[MDFR_ST_RATE]);
		clr;
		wt(2);
		chk("rate held", MDFR_BR_HIZ, BRIDGE_STATE);
		@(posedge SYS_CLK);
		POS_CURRENT_DECAYED <= 1'b1;
		clr;
		wt(2);
		chk("rate clear", MDFR_BR_ACTIVE, BRIDGE_STATE);
		$display("t_rate done");
	endtask
	task automatic t_pump;
		@(posedge SYS_CLK);
		CHARGE_PUMP_UNDERVOLTAGE <= 1'b1;
		wt(2);
		chk("pump bridge", MDFR_BR_HIZ, BRIDGE_STATE);
		chk("pump pin", 0, FAULT_OUT_N);
		bus(0, MDFR_STAT_ADDR, '0);
		chk("pump flags", 2'h3, {rd[MDFR_ST_CHARGE_PUMP_UNDERVOLTAGE], rd[MDFR_ST_DRV_FLT]});
		CHARGE_PUMP_UNDERVOLTAGE <= 1'b0;
		wt(3);
		chk("pump resume", {3'h0, 1'b1}, {BRIDGE_STATE, FAULT_OUT_N});
		bus(0, MDFR_STAT_ADDR, '0);
		chk("pump sticky", 1, rd[MDFR_ST_CHARGE_PUMP_UNDERVOLTAGE]);
		clr;
		bus(0, MDFR_STAT_ADDR, '0);
		chk("pump cleared", 0, rd[MDFR_ST_CHARGE_PUMP_UNDERVOLTAGE]);
		$display("t_pump done");
	endtask
	task automatic t_irq;
		bus(1, MDFR_MASK_ADDR, '0);
		CHARGE_PUMP_UNDERVOLTAGE <= 1'b1;
		@(posedge SYS_CLK);
		CHARGE_PUMP_UNDERVOLTAGE <= 1'b0;
		wt(2);
		chk("irq masked", 0, IRQ);
		bus(1, MDFR_MASK_ADDR, 32'h0000_0100);
		wt(1);
		chk("irq on", 1, IRQ);
		bus(1, MDFR_STAT_ADDR, 32'h0000_0100);
		wt(1);
		chk("irq w1c", 0, IRQ);
		$display("t_irq done");
	endtask
	// Each supply loss in turn must reset the settings
	task automatic t_supply;
		for (int k = 0; k < 3; k++) begin
			bus(1, MDFR_CFG_ADDR, 32'h0000_003F);
			{MAIN_SUPPLY_UV, ANALOG_REGULATOR_UV, BUCK_UNDERVOLTAGE} <= 3'h4 >> k;
			wt(1);
			chk("uv logic", 1, LOGIC_RST);
			chk("uv bridge", MDFR_BR_HIZ, BRIDGE_STATE);
			if (k < 2) chk("uv pump", 0, CHARGE_PUMP_EN);
			else chk("uv buck", 0, {BUCK_HS_EN, BUCK_LS_EN});
			@(posedge SYS_CLK);
			{MAIN_SUPPLY_UV, ANALOG_REGULATOR_UV, BUCK_UNDERVOLTAGE} <= '0;
			bus(0, MDFR_CFG_ADDR, '0);
			chk("uv cfg", MDFR_CFG_RESET, rd);
		end
		$display("t_supply done");
	endtask
	task automatic give_verdict;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard, several times the expected run
	initial begin
		#(40 * 6000);
		fails++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge SYS_CLK);
		RST <= 1'b0;
		t_reset;
		t_limit;
		t_report;
		t_ramp;
		t_rate;
		t_pump;
		t_irq;
		t_supply;
		chk("controller saw alarm", 1, seen);
		give_verdict;
	end
endmodule // testbench
